// >>> ffo_consts.svh
`ifndef FFO_CONSTS_SVH
`define FFO_CONSTS_SVH

// ============================================================
// register map (byte addresses)
`define FFO_ADDR_CTRL 8'h00
`define FFO_ADDR_STATUS 8'h04
`define FFO_ADDR_COUNT 8'h08
`define FFO_ADDR_OFFSETS 8'h0C
`define FFO_ADDR_SERPOS 8'h10
`define FFO_ADDR_EVENTS 8'h14

// ============================================================
// field positions
`define FFO_CTRL_SOFT_RST 0
`define FFO_ST_FLAGS_MSB 6
`define FFO_ST_VALID 8
`define FFO_ST_SERIAL 9
`define FFO_ST_FALL_THROUGH_MODE 10
`define FFO_OFF_FULL_LSB 16
`define FFO_EV_WR_REFUSED 0
`define FFO_EV_RD_EMPTY 1
`define FFO_EV_SER_DONE 2
`define FFO_EV_W 3

// ============================================================
// reset values and almost-empty threshold steps
`define FFO_OFF_DEF_PAR 16'h007F
`define FFO_OFF_DEF_SER 16'h03FF
`define FFO_FLAGS_RST 7'h4E
`define FFO_AE_STEP_STD 2'h1
`define FFO_AE_STEP_FT 2'h2

`endif

// >>> ffo_pkg.sv
package ffo_pkg;

  typedef struct packed {
    logic load_sel_n;
    logic serial_en_n;
    logic wen_n;
    logic ren_n;
    logic serial_in;
  } ffo_ctl_s;

  typedef struct packed {
    logic full_n;
    logic input_ready_n;
    logic empty_n;
    logic output_ready_n;
    logic half_full_n;
    logic almost_full_n;
    logic almost_empty_n;
  } ffo_flags_s;

  typedef enum logic [2:0] {
    FFO_PF_VALID = 3'b001,
    FFO_PF_LOAD = 3'b010,
    FFO_PF_SETTLE = 3'b100
  } ffo_pf_e;

endpackage : ffo_pkg

// >>> ffo_mem.sv
`timescale 1ns/1ps

// ============================================================
// simple dual-port word store, registered read data
module ffo_mem #(
  parameter int DW = 18,
  parameter int AW = 13
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // no reset on the array or read data so this maps onto block ram
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem_q[raddr];
    end
  end

endmodule : ffo_mem

// >>> ffo_flag_offset.sv
`timescale 1ns/1ps
`include "ffo_consts.svh"

module ffo_flag_offset #(
  parameter int AW = 13,
  parameter int DW = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_reset_n,
  input wire logic fall_through_mode,
  input wire ffo_pkg::ffo_ctl_s ctl,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output ffo_pkg::ffo_flags_s flags
);
  import ffo_pkg::*;

  localparam int CW = AW + 2;
  localparam int NB = 2 * AW;
  localparam int IW = $clog2(NB);
  localparam int SW = DW + 7;
  localparam logic [CW-1:0] DEPTH_C = CW'(1) << AW;
  localparam logic [IW-1:0] LAST_BIT = IW'(NB - 1);

  // ============================================================
  // pin synchronisers
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {master_reset_n, fall_through_mode, ctl, data_in};
      sync2_q <= sync1_q;
    end
  end

  wire logic mrs_n_s;
  wire logic fall_through_mode_s;
  ffo_ctl_s c_s;
  wire logic [DW-1:0] din_s;
  assign mrs_n_s = sync2_q[SW-1];
  assign fall_through_mode_s = sync2_q[SW-2];
  assign c_s = ffo_ctl_s'(sync2_q[DW+4:DW]);
  assign din_s = sync2_q[DW-1:0];

  // ============================================================
  // state
  logic soft_rst_q;
  logic serial_mode_q;
  logic fall_through_mode_q;
  logic [AW-1:0] e_off_q;
  logic [AW-1:0] f_off_q;
  logic wsel_q;
  logic rsel_q;
  logic [IW-1:0] ser_idx_q;
  logic [AW:0] wptr_q;
  logic [AW:0] rptr_q;
  logic [CW-1:0] count_q;
  logic ov_q;
  logic rdv_q;
  logic [DW-1:0] data_out_q;
  ffo_flags_s flags_q;
  ffo_pf_e pf_q;
  ffo_pf_e pf_d;
  logic [`FFO_EV_W-1:0] events_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [DW-1:0] mem_rdata;

  wire logic mrst;
  assign mrst = ~mrs_n_s | soft_rst_q;

  // ============================================================
  // operation decode from the control pins
  wire logic ld_hi;
  wire logic off_wr;
  wire logic off_rd;
  wire logic ser_sh;
  wire logic ser_last;
  assign ld_hi = c_s.load_sel_n;
  // offset write only in the method chosen at reset
  assign off_wr = ~ld_hi & ~c_s.wen_n & c_s.ren_n & c_s.serial_en_n & ~serial_mode_q;
  assign off_rd = ~ld_hi & c_s.wen_n & ~c_s.ren_n & c_s.serial_en_n;
  // serial enable high blocks the shift
  assign ser_sh = ~ld_hi & ~c_s.serial_en_n & c_s.wen_n & c_s.ren_n & serial_mode_q;
  assign ser_last = ser_sh & (ser_idx_q == LAST_BIT);

  // ============================================================
  // word count and memory access
  wire logic [AW:0] mem_cnt;
  wire logic [CW-1:0] cap;
  wire logic full_c;
  wire logic mem_full;
  wire logic wr_req;
  wire logic wr_mem;
  wire logic rd_req;
  wire logic rd_std;
  wire logic rd_ft;
  wire logic pf_issue;
  wire logic mem_re;
  wire logic [CW-1:0] count_d;
  assign mem_cnt = wptr_q - rptr_q;
  assign cap = DEPTH_C + CW'(fall_through_mode_q);
  assign full_c = (count_q == cap);
  assign mem_full = mem_cnt[AW];
  assign wr_req = ld_hi & ~c_s.wen_n;
  assign wr_mem = wr_req & ~full_c & ~mem_full & ~mrst;
  assign rd_req = ld_hi & ~c_s.ren_n;
  assign rd_std = rd_req & ~fall_through_mode_q & (count_q != '0) & ~mrst;
  assign rd_ft = rd_req & fall_through_mode_q & ov_q & ~mrst;
  // output register refills itself in fall-through timing
  assign pf_issue = fall_through_mode_q & (mem_cnt != '0) & ~rdv_q & (~ov_q | rd_ft) & ~mrst;
  assign mem_re = rd_std | pf_issue;
  assign count_d = count_q + CW'(wr_mem) - CW'(rd_std | rd_ft);

  ffo_mem #(
    .DW(DW),
    .AW(AW)
  ) u_mem (
    .clk(pclk),
    .we(wr_mem),
    .waddr(wptr_q[AW-1:0]),
    .wdata(din_s),
    .re(mem_re),
    .raddr(rptr_q[AW-1:0]),
    .rdata(mem_rdata)
  );

  // ============================================================
  // flag thresholds
  wire logic [CW-1:0] ae_thr;
  wire logic [CW-1:0] af_thr;
  wire logic [CW-1:0] hf_thr;
  wire logic pf_ok;
  ffo_flags_s flags_d;
  assign ae_thr = CW'(e_off_q) + CW'(fall_through_mode_q ? `FFO_AE_STEP_FT : `FFO_AE_STEP_STD);
  assign af_thr = cap - CW'(f_off_q);
  assign hf_thr = (DEPTH_C >> 1) + CW'(fall_through_mode_q);
  assign pf_ok = (pf_q == FFO_PF_VALID);
  assign flags_d.full_n = ~full_c;
  assign flags_d.input_ready_n = full_c;
  assign flags_d.empty_n = (count_q != '0);
  assign flags_d.output_ready_n = fall_through_mode_q ? ~ov_q : (count_q == '0);
  assign flags_d.half_full_n = ~(count_q > hf_thr);
  // partial flags hold while the offsets are being reloaded serially; parallel offset writes do not hold them
  assign flags_d.almost_full_n = pf_ok ? ~(count_q >= af_thr) : flags_q.almost_full_n;
  assign flags_d.almost_empty_n = pf_ok ? (count_q >= ae_thr) : flags_q.almost_empty_n;

  // ============================================================
  // partial flag validity sequence
  always_comb begin
    pf_d = pf_q;
    case (pf_q)
      FFO_PF_VALID: begin
        if (ser_sh) begin
          pf_d = ser_last ? FFO_PF_SETTLE : FFO_PF_LOAD;
        end
      end
      FFO_PF_LOAD: begin
        if (ser_last) begin
          pf_d = FFO_PF_SETTLE;
        end
      end
      FFO_PF_SETTLE: begin
        // one more edge, then flags recompute on the following one
        pf_d = (ser_sh && !ser_last) ? FFO_PF_LOAD : FFO_PF_VALID;
      end
      default: begin
        pf_d = FFO_PF_VALID;
      end
    endcase
  end

  // ============================================================
  // offset registers
  logic [NB-1:0] off_all_d;
  always_comb begin
    off_all_d = {f_off_q, e_off_q};
    if (off_wr) begin
      if (wsel_q) begin
        off_all_d[NB-1:AW] = din_s[AW-1:0];
      end else begin
        off_all_d[AW-1:0] = din_s[AW-1:0];
      end
    end
    if (ser_sh) begin
      off_all_d[ser_idx_q] = c_s.serial_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_q <= 1'b0;
      fall_through_mode_q <= 1'b0;
      e_off_q <= AW'(`FFO_OFF_DEF_PAR);
      f_off_q <= AW'(`FFO_OFF_DEF_PAR);
      wsel_q <= 1'b0;
      rsel_q <= 1'b0;
      ser_idx_q <= '0;
      pf_q <= FFO_PF_VALID;
    end else if (mrst) begin
      // straps are caught only while master reset is applied
      serial_mode_q <= c_s.load_sel_n;
      fall_through_mode_q <= fall_through_mode_s;
      e_off_q <= AW'(c_s.load_sel_n ? `FFO_OFF_DEF_SER : `FFO_OFF_DEF_PAR);
      f_off_q <= AW'(c_s.load_sel_n ? `FFO_OFF_DEF_SER : `FFO_OFF_DEF_PAR);
      wsel_q <= 1'b0;
      rsel_q <= 1'b0;
      ser_idx_q <= '0;
      pf_q <= FFO_PF_VALID;
    end else begin
      {f_off_q, e_off_q} <= off_all_d;
      pf_q <= pf_d;
      if (off_wr) begin
        wsel_q <= ~wsel_q;
      end
      if (off_rd) begin
        rsel_q <= ~rsel_q;
      end
      // position survives pauses in the load
      if (ser_sh) begin
        ser_idx_q <= ser_last ? '0 : ser_idx_q + IW'(1);
      end
    end
  end

  // ============================================================
  // data path and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      ov_q <= 1'b0;
      rdv_q <= 1'b0;
      data_out_q <= '0;
      flags_q <= ffo_flags_s'(`FFO_FLAGS_RST);
    end else if (mrst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      ov_q <= 1'b0;
      rdv_q <= 1'b0;
      data_out_q <= '0;
      flags_q <= ffo_flags_s'(`FFO_FLAGS_RST);
    end else begin
      wptr_q <= wptr_q + (AW+1)'(wr_mem);
      rptr_q <= rptr_q + (AW+1)'(mem_re);
      count_q <= count_d;
      rdv_q <= mem_re;
      if (rdv_q && fall_through_mode_q) begin
        ov_q <= 1'b1;
      end else if (rd_ft) begin
        ov_q <= 1'b0;
      end
      // offset readback overwrites whatever word was on the outputs
      if (off_rd) begin
        data_out_q <= DW'(rsel_q ? f_off_q : e_off_q);
      end else if (rdv_q) begin
        data_out_q <= mem_rdata;
      end
      flags_q <= flags_d;
    end
  end

  assign data_out = data_out_q;
  assign flags = flags_q;

  // ============================================================
  // register bus
  wire logic hit_ctrl;
  wire logic hit_status;
  wire logic hit_count;
  wire logic hit_offsets;
  wire logic hit_serpos;
  wire logic hit_events;
  wire logic addr_ok;
  wire logic apb_wr;
  wire logic [31:0] status_w;
  wire logic [31:0] offsets_w;
  wire logic [31:0] rd_data_w;
  wire logic [`FFO_EV_W-1:0] ev_set;
  wire logic [`FFO_EV_W-1:0] ev_clr;
  assign hit_ctrl = (paddr == `FFO_ADDR_CTRL);
  assign hit_status = (paddr == `FFO_ADDR_STATUS);
  assign hit_count = (paddr == `FFO_ADDR_COUNT);
  assign hit_offsets = (paddr == `FFO_ADDR_OFFSETS);
  assign hit_serpos = (paddr == `FFO_ADDR_SERPOS);
  assign hit_events = (paddr == `FFO_ADDR_EVENTS);
  assign addr_ok = hit_ctrl | hit_status | hit_count | hit_offsets | hit_serpos | hit_events;
  assign apb_wr = psel & penable & pwrite & pready_q;
  assign status_w = 32'(flags_q) | (32'(pf_ok) << `FFO_ST_VALID)
                    | (32'(serial_mode_q) << `FFO_ST_SERIAL) | (32'(fall_through_mode_q) << `FFO_ST_FALL_THROUGH_MODE);
  assign offsets_w = 32'(e_off_q) | (32'(f_off_q) << `FFO_OFF_FULL_LSB);
  assign rd_data_w = hit_status ? status_w :
                     hit_count ? 32'(count_q) :
                     hit_offsets ? offsets_w :
                     hit_serpos ? 32'(ser_idx_q) :
                     hit_events ? 32'(events_q) : 32'h0000_0000;
  // sticky events: refused write, read while empty, serial load finished
  assign ev_set = {ser_last, rd_req & ~rd_std & ~rd_ft & ~mrst, wr_req & ~wr_mem & ~mrst};
  assign ev_clr = (apb_wr && hit_events) ? pwdata[`FFO_EV_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      soft_rst_q <= 1'b0;
      events_q <= '0;
    end else begin
      // answer in the first access cycle, no wait states
      pready_q <= psel & ~penable;
      // read data and error stand only in the access cycle, zero otherwise
      prdata_q <= (psel && !penable && !pwrite) ? rd_data_w : 32'h0000_0000;
      pslverr_q <= psel & ~penable & ~addr_ok;
      // one-cycle pulse, joins the synchronised master reset path
      soft_rst_q <= apb_wr & hit_ctrl & pwdata[`FFO_CTRL_SOFT_RST];
      // a new event in the clearing cycle is kept
      events_q <= (events_q & ~ev_clr) | ev_set;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : ffo_flag_offset

// >>> ffo_flag_offset_assertions.sv
`timescale 1ns/1ps
// ============
// protocol and flag checks at the top ports
module ffo_flag_offset_assertions #(
  parameter int AW = 13,
  parameter int DW = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic master_reset_n,
  input wire logic fall_through_mode,
  input wire ffo_pkg::ffo_ctl_s ctl,
  input wire logic [DW-1:0] data_in,
  input wire logic [DW-1:0] data_out,
  input wire ffo_pkg::ffo_flags_s flags
);
  import ffo_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  ready_after_setup_a: assert property (setup |=> pready)
    else $error("ready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero while idle");
  unmapped_error_a: assert property (setup && paddr > 8'h14 |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
  mapped_ok_a: assert property (setup && paddr <= 8'h14 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped address refused");
  // six quiet edges cover sync delay plus read pipeline
  output_hold_a: assert property ((ctl.ren_n && master_reset_n && !fall_through_mode)[*6]
    |-> $stable(data_out)) else $error("data out moved without a read");
  full_pair_a: assert property (flags.input_ready_n == !flags.full_n)
    else $error("full and input ready disagree");
  empty_pair_a: assert property (!fall_through_mode |-> flags.output_ready_n == !flags.empty_n)
    else $error("empty and output ready disagree");
  ready_has_data_a: assert property (!flags.output_ready_n |-> flags.empty_n)
    else $error("output ready while no word stored");
  full_half_a: assert property (!flags.full_n |-> !flags.half_full_n)
    else $error("full without half full");
  cover property (!flags.full_n);
  cover property (pslverr);
  cover property (!flags.half_full_n && flags.full_n);
  cover property (fall_through_mode && !flags.output_ready_n);
endmodule : ffo_flag_offset_assertions

bind ffo_flag_offset ffo_flag_offset_assertions #(.AW(AW), .DW(DW)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .master_reset_n(master_reset_n), .fall_through_mode(fall_through_mode), .ctl(ctl),
  .data_in(data_in), .data_out(data_out), .flags(flags)
);

// >>> ffo_host.sv
`timescale 1ns/1ps
// ============
// host model on the fifo pins, one operation per clock
module ffo_host (
  input wire logic pclk,
  output ffo_pkg::ffo_ctl_s ctl,
  output logic [17:0] data_in,
  output logic master_reset_n
);
  import ffo_pkg::*;
  initial begin
    ctl = 5'h1E;
    data_in = 18'h3FFFF;
    master_reset_n = 1'b1;
  end
  // idle edge at the end keeps calls from colliding
  task automatic drive(input logic [4:0] c, input logic [17:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      ctl <= c;
      data_in <= d + 18'(i);
      @(posedge pclk);
    end
    ctl <= 5'h1E;
    data_in <= ~d;
    @(posedge pclk);
  endtask : drive
  task automatic shift(input logic [27:0] v, input int lo, input int hi);
    for (int i = lo; i < hi; i++) begin
      ctl <= {4'h3, v[i]};
      @(posedge pclk);
    end
    ctl <= 5'h1E;
    @(posedge pclk);
  endtask : shift
  task automatic mreset(input logic ld);
    ctl <= {ld, 4'hE};
    master_reset_n <= 1'b0;
    repeat (6) @(posedge pclk);
    master_reset_n <= 1'b1;
    repeat (6) @(posedge pclk);
    ctl <= 5'h1E;
    @(posedge pclk);
  endtask : mreset
endmodule : ffo_host

// >>> tb_top.sv
`timescale 1ns/1ps
`include "ffo_consts.svh"
// ============
// bench: pin host model plus apb master
module tb_top;
  import ffo_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mrst_n, ftm, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [17:0] din, dout;
  ffo_ctl_s ctl;
  ffo_flags_s flags;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  ffo_flag_offset #(.AW(13), .DW(18)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_reset_n(mrst_n), .fall_through_mode(ftm), .ctl(ctl), .data_in(din),
    .data_out(dout), .flags(flags));
  ffo_host i_host (.pclk(pclk), .ctl(ctl), .data_in(din), .master_reset_n(mrst_n));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask : settle
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ftm = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    // power-up master reset sees zeroed sync flops, so strap serial explicitly
    i_host.mreset(1'b1);
    apb(1'b0, `FFO_ADDR_STATUS, 32'h0);
    chk({21'h0, rd[10:0]}, 32'h0000034E);
    rdchk(`FFO_ADDR_OFFSETS, 32'h03FF03FF);
    i_host.drive(5'h0A, 18'h00005, 1);
    settle;
    rdchk(`FFO_ADDR_OFFSETS, 32'h03FF03FF);
    i_host.shift(28'h0012005, 0, 3);
    i_host.mreset(1'b1);
    rdchk(`FFO_ADDR_SERPOS, 32'h0);
    i_host.shift(28'h0012005, 0, 10);
    i_host.drive(5'h0E, 18'h00000, 3);
    i_host.drive(5'h1A, 18'h01234, 1);
    settle;
    rdchk(`FFO_ADDR_SERPOS, 32'hA);
    rdchk(`FFO_ADDR_COUNT, 32'h1);
    i_host.shift(28'h0012005, 10, 26);
    settle;
    rdchk(`FFO_ADDR_OFFSETS, 32'h00090005);
    rdchk(`FFO_ADDR_SERPOS, 32'h0);
    for (int i = 5; i < 10; i += 4) begin
      i_host.drive(5'h0C, 18'h00000, 1);
      settle;
      chk(32'(dout), 32'(i));
    end
    i_host.drive(5'h1A, 18'h00100, 4);
    settle;
    chk(32'(flags.almost_empty_n), 32'h0);
    i_host.drive(5'h1A, 18'h00200, 1);
    settle;
    chk(32'(flags.almost_empty_n), 32'h1);
    i_host.drive(5'h1C, 18'h00000, 1);
    settle;
    chk(32'(dout), 32'h01234);
    chk(32'(flags.almost_empty_n), 32'h0);
    i_host.mreset(1'b0);
    rdchk(`FFO_ADDR_OFFSETS, 32'h007F007F);
    rdchk(`FFO_ADDR_COUNT, 32'h0);
    i_host.drive(5'h0A, 18'h00003, 1);
    i_host.drive(5'h0A, 18'h00011, 1);
    i_host.shift(28'hFFFFFFF, 0, 4);
    settle;
    rdchk(`FFO_ADDR_OFFSETS, 32'h00110003);
    i_host.drive(5'h1A, 18'h00000, 4096);
    settle;
    chk(32'(flags.half_full_n), 32'h1);
    i_host.drive(5'h1A, 18'h00000, 1);
    settle;
    chk(32'(flags.half_full_n), 32'h0);
    // one write beyond capacity must be refused
    i_host.drive(5'h1A, 18'h00000, 4096);
    settle;
    rdchk(`FFO_ADDR_COUNT, 32'h2000);
    chk({30'h0, flags.full_n, flags.almost_full_n}, 32'h0);
    apb(1'b0, `FFO_ADDR_EVENTS, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h5);
    apb(1'b1, `FFO_ADDR_EVENTS, 32'h7);
    rdchk(`FFO_ADDR_EVENTS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    // fall-through timing: output register holds one extra word
    ftm <= 1'b1;
    i_host.mreset(1'b0);
    i_host.drive(5'h1A, 18'h00700, 128);
    settle;
    chk(32'(dout), 32'h00700);
    chk(32'(flags.almost_empty_n), 32'h0);
    i_host.drive(5'h1A, 18'h00000, 1);
    settle;
    chk(32'(flags.almost_empty_n), 32'h1);
    i_host.drive(5'h1A, 18'h00000, 8065);
    settle;
    rdchk(`FFO_ADDR_COUNT, 32'h2001);
    chk(32'(flags.input_ready_n), 32'h1);
    wrap_up;
  end
endmodule : tb_top
